/* ddic_top.sv */
// ddic_top: decode pairing, front-end stalls, issue control and front-end events
// assumes fetch presents two predecoded instructions per thread, slot0 older than slot1
`timescale 1ns/1ps

module ddic_top (
	input wire logic i_clk,
	input wire logic i_resetn,
	input ddic_pkg::ddic_inst_t i_t0_slot0,
	input ddic_pkg::ddic_inst_t i_t0_slot1,
	input ddic_pkg::ddic_inst_t i_t1_slot0,
	input ddic_pkg::ddic_inst_t i_t1_slot1,
	input wire logic [1:0] i_queue_oldest,
	input wire logic i_bp_lookup,
	input wire logic [ddic_pkg::ADDR_W-1:0] i_bp_pc,
	input wire logic i_bp_update,
	input wire logic [ddic_pkg::ADDR_W-1:0] i_bp_upd_pc,
	input wire logic i_bp_taken,
	input wire logic i_front_end_branch_clear,
	input wire logic i_icache_miss,
	input wire logic i_branch_mispredict_retired,
	input wire logic [1:0] i_retire_count,
	output logic o_thread,
	output logic [1:0] o_consume,
	output logic o_issue0,
	output logic o_issue1,
	output logic o_issue0_port,
	output logic o_bp_predict_taken,
	output logic o_microcoded_decode_event,
	output logic [1:0] o_direct_decode_event,
	output logic o_decode_stall_event,
	output logic o_front_end_branch_clear_event,
	output logic o_instruction_cache_miss_event,
	output logic o_branch_type_mispredict_event,
	output logic [1:0] o_retire_count
);
	// ----------------------------------------
	// thread select
	// ----------------------------------------
	logic thr_q;
	ddic_pkg::ddic_state_t st_q;
	ddic_pkg::ddic_state_t st_d;
	logic [1:0] dly_q;
	logic [1:0] dly_d;
	wire t0_rdy = i_t0_slot0.valid;
	wire t1_rdy = i_t1_slot0.valid;
	ddic_pkg::ddic_inst_t s0;
	ddic_pkg::ddic_inst_t s1;
	assign s0 = thr_q ? i_t1_slot0 : i_t0_slot0;
	assign s1 = thr_q ? i_t1_slot1 : i_t0_slot1;

	// ----------------------------------------
	// decode pairing
	// ----------------------------------------
	wire ucode0 = s0.complex_op || s0.len > 4'(ddic_pkg::MAX_DIRECT_LEN)
		|| s0.prefixes > 3'(ddic_pkg::MAX_PREFIXES);
	wire ucode1 = s1.complex_op || s1.len > 4'(ddic_pkg::MAX_DIRECT_LEN)
		|| s1.prefixes > 3'(ddic_pkg::MAX_PREFIXES);
	wire [ddic_pkg::ADDR_W-1:0] pair_end = s0.addr + ddic_pkg::ADDR_W'(s0.len)
		+ ddic_pkg::ADDR_W'(s1.len) - ddic_pkg::ADDR_W'(1);
	wire cross16 = s0.valid && s1.valid &&
		(s0.addr[ddic_pkg::ADDR_W-1:4] != pair_end[ddic_pkg::ADDR_W-1:4]);
	// second slot drops at a jump, a second float stack op, or any microcode need
	wire pair_ok = s1.valid && !ucode0 && !ucode1 && !s0.jump
		&& !(s0.legacy_float_stack_instruction && s1.legacy_float_stack_instruction);
	wire [5:0] bytes_now = 6'(s0.len) + (pair_ok ? 6'(s1.len) : 6'h0);

	// ----------------------------------------
	// 7-cycle byte window
	// ----------------------------------------
	logic [4:0] win_q [ddic_pkg::WIN_CYCLES-1];
	logic [ddic_pkg::WSUM_W-1:0] win_sum;
	always_comb begin
		win_sum = '0;
		for (int k = 0; k < int'(ddic_pkg::WIN_CYCLES) - 1; k++) begin
			win_sum = win_sum + ddic_pkg::WSUM_W'(win_q[k]);
		end
	end
	wire win_stall = s0.valid &&
		(win_sum + ddic_pkg::WSUM_W'(bytes_now) > ddic_pkg::WSUM_W'(ddic_pkg::WIN_BYTES));

	// ----------------------------------------
	// front-end sequencer
	// ----------------------------------------
	wire run = st_q == ddic_pkg::DDIC_RUN;
	wire go_ucode = run && s0.valid && ucode0 && !win_stall;
	wire go_hold = run && pair_ok && cross16 && !win_stall;
	wire dec_fire = run && s0.valid && !ucode0 && !win_stall && !(pair_ok && cross16);
	always_comb begin
		st_d = st_q;
		dly_d = dly_q;
		case (st_q)
			ddic_pkg::DDIC_RUN: begin
				if (go_ucode) begin
					st_d = ddic_pkg::DDIC_UCODE;
					dly_d = 2'(ddic_pkg::UCODE_DELAY - 1);
				end else if (go_hold) begin
					st_d = ddic_pkg::DDIC_HOLD;
				end
			end
			ddic_pkg::DDIC_UCODE: begin
				if (dly_q == 2'h0) begin
					st_d = ddic_pkg::DDIC_RUN;
				end else begin
					dly_d = dly_q - 2'h1;
				end
			end
			ddic_pkg::DDIC_HOLD: begin
				st_d = ddic_pkg::DDIC_RUN;
			end
			default: begin
				st_d = ddic_pkg::DDIC_RUN;
			end
		endcase
	end
	wire ucode_done = st_q == ddic_pkg::DDIC_UCODE && dly_q == 2'h0;
	wire hold_done = st_q == ddic_pkg::DDIC_HOLD;
	// fairness: alternate when both ready; keep the thread while its microcode or hold runs,
	// otherwise the delayed issue would pick up the other thread's slot
	wire thr_next = (st_q != ddic_pkg::DDIC_RUN || go_ucode || go_hold) ? thr_q :
		(t0_rdy && t1_rdy) ? !thr_q : t1_rdy;

	// ----------------------------------------
	// issue check
	// ----------------------------------------
	ddic_issue_if iss ();
	ddic_pkg::ddic_inst_t gate0;
	ddic_pkg::ddic_inst_t gate1;
	// slots reach the hazard check only when the front end delivers them, so producer
	// tracking never counts an instruction that was not really issued
	always_comb begin
		gate0 = s0;
		gate0.valid = s0.valid && (dec_fire || ucode_done || hold_done);
		gate1 = s1;
		gate1.valid = s1.valid && pair_ok && (dec_fire || hold_done);
	end
	assign iss.slot0 = gate0;
	assign iss.slot1 = gate1;
	assign iss.thread = thr_q;
	assign iss.queue_oldest = i_queue_oldest[thr_q];
	ddic_issue_check u_check (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.bus(iss.check)
	);
	// decode pair consumed only where both front end and issue accept it
	wire fe_go = dec_fire || ucode_done || hold_done;
	wire take0 = fe_go && iss.issue0;
	wire take1 = take0 && iss.issue1 && (dec_fire || hold_done);
	wire [5:0] bytes_take = 6'(s0.len) + (take1 ? 6'(s1.len) : 6'h0);
	wire stall_ev = run && s0.valid && (win_stall || (s1.valid && !pair_ok) || cross16);

	// ----------------------------------------
	// shared branch predictor
	// ----------------------------------------
	logic [1:0] bp_q [2**ddic_pkg::BP_IDX_W];
	wire [ddic_pkg::BP_IDX_W-1:0] bp_ri = i_bp_pc[ddic_pkg::BP_IDX_W-1:0];
	wire [ddic_pkg::BP_IDX_W-1:0] bp_wi = i_bp_upd_pc[ddic_pkg::BP_IDX_W-1:0];
	wire [1:0] bp_cur = bp_q[bp_wi];
	// one table for every branch kind, so kinds alias freely by address bits
	wire [1:0] bp_nxt = i_bp_taken ? (bp_cur == 2'h3 ? bp_cur : bp_cur + 2'h1) :
		(bp_cur == 2'h0 ? bp_cur : bp_cur - 2'h1);
	genvar e;
	generate
		for (e = 0; e < 2**ddic_pkg::BP_IDX_W; e++) begin : g_bp
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					bp_q[e] <= 2'h1;
				end else if (i_bp_update && bp_wi == ddic_pkg::BP_IDX_W'(e)) begin
					bp_q[e] <= bp_nxt;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic port_q;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= ddic_pkg::DDIC_RUN;
			dly_q <= 2'h0;
			thr_q <= 1'b0;
			port_q <= 1'b0;
			for (int k = 0; k < int'(ddic_pkg::WIN_CYCLES) - 1; k++) begin
				win_q[k] <= 5'h0;
			end
		end else begin
			st_q <= st_d;
			dly_q <= dly_d;
			thr_q <= thr_next;
			port_q <= port_q ^ take1;
			win_q[0] <= take0 ? 5'(bytes_take) : 5'h0;
			for (int k = 1; k < int'(ddic_pkg::WIN_CYCLES) - 1; k++) begin
				win_q[k] <= win_q[k-1];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_thread <= 1'b0;
			o_consume <= 2'h0;
			o_issue0 <= 1'b0;
			o_issue1 <= 1'b0;
			o_issue0_port <= 1'b0;
			o_bp_predict_taken <= 1'b0;
			o_microcoded_decode_event <= 1'b0;
			o_direct_decode_event <= 2'h0;
			o_decode_stall_event <= 1'b0;
			o_front_end_branch_clear_event <= 1'b0;
			o_instruction_cache_miss_event <= 1'b0;
			o_branch_type_mispredict_event <= 1'b0;
			o_retire_count <= 2'h0;
		end else begin
			o_thread <= thr_q;
			o_consume <= {take1, take0};
			o_issue0 <= take0;
			o_issue1 <= take1;
			o_issue0_port <= port_q;
			o_bp_predict_taken <= i_bp_lookup && bp_q[bp_ri][1];
			o_microcoded_decode_event <= go_ucode;
			o_direct_decode_event <= {take1, take0 && !ucode_done};
			o_decode_stall_event <= stall_ev;
			o_front_end_branch_clear_event <= i_front_end_branch_clear;
			o_instruction_cache_miss_event <= i_icache_miss;
			o_branch_type_mispredict_event <= i_branch_mispredict_retired;
			o_retire_count <= (i_retire_count > 2'h2) ? 2'h2 : i_retire_count;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_jump_last;
		@(posedge i_clk) disable iff (!i_resetn)
		(take1) |-> !s0.jump;
	endproperty
	a_jump_last: assert property (p_jump_last) else $error("instruction decoded after jump");

	property p_one_float;
		@(posedge i_clk) disable iff (!i_resetn)
		take1 |-> !(s0.legacy_float_stack_instruction && s1.legacy_float_stack_instruction);
	endproperty
	a_one_float: assert property (p_one_float) else $error("two float stack ops in one cycle");

	property p_ucode_delay;
		@(posedge i_clk) disable iff (!i_resetn)
		go_ucode |=> st_q == ddic_pkg::DDIC_UCODE ##1 st_q == ddic_pkg::DDIC_UCODE ##1 run;
	endproperty
	a_ucode_delay: assert property (p_ucode_delay) else $error("microcode delay not two cycles");

	property p_ucode_slot0;
		@(posedge i_clk) disable iff (!i_resetn)
		(st_q == ddic_pkg::DDIC_UCODE) |-> !take1;
	endproperty
	a_ucode_slot0: assert property (p_ucode_slot0) else $error("slot 1 paired with microcode");

	property p_cross_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		go_hold |=> hold_done && !dec_fire;
	endproperty
	a_cross_hold: assert property (p_cross_hold) else $error("16 byte crossing not held");

	property p_window;
		@(posedge i_clk) disable iff (!i_resetn)
		take0 |-> win_sum + ddic_pkg::WSUM_W'(bytes_take) <=
			ddic_pkg::WSUM_W'(ddic_pkg::WIN_BYTES);
	endproperty
	a_window: assert property (p_window) else $error("byte window exceeded");
endmodule : ddic_top

/* ddic_pkg.sv */
// ddic_pkg: constants and types for the dual decode / in-order issue control block
// assumes one core clock; instruction attributes arrive predecoded from fetch buffers

package ddic_pkg;
	localparam int unsigned MAX_DIRECT_LEN = 8;
	localparam int unsigned MAX_PREFIXES = 3;
	localparam int unsigned WIN_CYCLES = 7;
	localparam int unsigned WIN_BYTES = 48;
	localparam int unsigned LINE_BYTES = 16;
	localparam int unsigned UCODE_DELAY = 2;
	localparam int unsigned FLAG_OTHER_DELAY = 2;
	localparam int unsigned LONG_LAT_CYCLES = 4;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned LEN_W = 4;
	localparam int unsigned PFX_W = 3;
	localparam int unsigned REG_W = 4;
	localparam int unsigned WSUM_W = 7;
	localparam int unsigned BP_IDX_W = 6;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] len;
		logic [PFX_W-1:0] prefixes;
		logic complex_op;
		logic jump;
		logic cond_jump;
		logic legacy_float_stack_instruction;
		logic flag_write;
		logic flag_read_carry;
		logic flag_read_other;
		logic long_lat;
		logic expensive;
		logic dst_valid;
		logic [REG_W-1:0] dst;
	} ddic_inst_t;

	typedef enum logic [1:0] {
		DDIC_RUN = 2'b00,
		DDIC_UCODE = 2'b01,
		DDIC_HOLD = 2'b10
	} ddic_state_t;
endpackage : ddic_pkg

/* ddic_issue_if.sv */
// ddic_issue_if: issue hazard inputs and decisions between decode and issue check
// assumes both ends on the same core clock
`timescale 1ns/1ps

interface ddic_issue_if;
	ddic_pkg::ddic_inst_t slot0;
	ddic_pkg::ddic_inst_t slot1;
	logic thread;
	logic queue_oldest;
	logic issue0;
	logic issue1;

	modport decode(output slot0, output slot1, output thread, output queue_oldest,
		input issue0, input issue1);
	modport check(input slot0, input slot1, input thread, input queue_oldest,
		output issue0, output issue1);
endinterface : ddic_issue_if

/* ddic_issue_check.sv */
// ddic_issue_check: same-cycle issue hazards for a decoded pair
// assumes slot0 is older than slot1 and both belong to the selected thread
`timescale 1ns/1ps

module ddic_issue_check (
	input wire logic i_clk,
	input wire logic i_resetn,
	ddic_issue_if.check bus
);
	// ----------------------------------------
	// producer tracking
	// ----------------------------------------
	logic [1:0] flag_age_q;
	logic [1:0] flag_age_d;
	logic [2:0] long_cnt_q [2];
	logic [2:0] long_cnt_d [2];
	logic long_both_q;
	wire flag_new = (bus.issue0 && bus.slot0.flag_write) || (bus.issue1 && bus.slot1.flag_write);
	wire long_new = (bus.issue0 && bus.slot0.long_lat) || (bus.issue1 && bus.slot1.long_lat);

	// age counts cycles since the last flag producer issued; 0 means none pending
	assign flag_age_d = flag_new ? 2'h1 :
		(flag_age_q != 2'h0 && flag_age_q < 2'(ddic_pkg::FLAG_OTHER_DELAY)) ? flag_age_q + 2'h1 : 2'h0;

	genvar t;
	generate
		for (t = 0; t < 2; t++) begin : g_thr
			assign long_cnt_d[t] = (long_new && bus.thread == 1'(t)) ?
				3'(ddic_pkg::LONG_LAT_CYCLES) :
				(long_cnt_q[t] != 3'h0 ? long_cnt_q[t] - 3'h1 : 3'h0);
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					long_cnt_q[t] <= 3'h0;
				end else begin
					long_cnt_q[t] <= long_cnt_d[t];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_age_q <= 2'h0;
			long_both_q <= 1'b0;
		end else begin
			flag_age_q <= flag_age_d;
			long_both_q <= long_new;
		end
	end

	// ----------------------------------------
	// slot hazards
	// ----------------------------------------
	wire thr_long = long_cnt_q[bus.thread] != 3'h0;
	// carry readers and conditional jumps go one cycle after the writer; others wait two
	function automatic logic flag_block(input ddic_pkg::ddic_inst_t i, input logic [1:0] age);
		flag_block = i.flag_read_other && age == 2'h1;
	endfunction
	function automatic logic blocked(input ddic_pkg::ddic_inst_t i, input logic tl,
		input logic lb, input logic [1:0] age);
		blocked = (flag_block(i, age)) || (!i.long_lat && (tl || lb));
	endfunction

	wire b0 = !bus.slot0.valid || blocked(bus.slot0, thr_long, long_both_q, flag_age_q)
		|| (bus.slot0.expensive && !bus.queue_oldest);
	wire pair_flag = bus.slot0.flag_write &&
		(bus.slot1.flag_read_carry || bus.slot1.flag_read_other || bus.slot1.cond_jump);
	wire pair_dst = bus.slot0.dst_valid && bus.slot1.dst_valid &&
		bus.slot0.dst == bus.slot1.dst;
	wire pair_long = bus.slot0.long_lat && !bus.slot1.long_lat;
	wire b1 = !bus.slot1.valid || b0 || pair_flag || pair_dst || pair_long
		|| bus.slot1.expensive || blocked(bus.slot1, thr_long, long_both_q, flag_age_q);

	assign bus.issue0 = !b0;
	assign bus.issue1 = !b1;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_flag_pair;
		@(posedge i_clk) disable iff (!i_resetn)
		(bus.issue0 && bus.slot0.flag_write && bus.slot1.flag_read_carry) |-> !bus.issue1;
	endproperty
	a_flag_pair: assert property (p_flag_pair) else $error("flag reader issued with writer");

	property p_dst_pair;
		@(posedge i_clk) disable iff (!i_resetn)
		(bus.issue1 && bus.slot0.dst_valid && bus.slot1.dst_valid) |-> bus.slot0.dst != bus.slot1.dst;
	endproperty
	a_dst_pair: assert property (p_dst_pair) else $error("common destination issued together");

	property p_other_flag;
		@(posedge i_clk) disable iff (!i_resetn)
		flag_new |=> !(bus.issue0 && bus.slot0.flag_read_other);
	endproperty
	a_other_flag: assert property (p_other_flag) else $error("other-flag reader too early");

	property p_long_both;
		@(posedge i_clk) disable iff (!i_resetn)
		long_new |=> !(bus.issue0 && !bus.slot0.long_lat);
	endproperty
	a_long_both: assert property (p_long_both) else $error("short op issued after long op");

	property p_expensive;
		@(posedge i_clk) disable iff (!i_resetn)
		(bus.issue0 && bus.slot0.expensive) |-> bus.queue_oldest;
	endproperty
	a_expensive: assert property (p_expensive) else $error("expensive op issued while not oldest");
endmodule : ddic_issue_check

/* ddic_fetch_model.sv */
// ddic_fetch_model: fetch buffer stand-in, one instruction queue per thread
// assumes consume pulses refer to the thread shown on the thread output
`timescale 1ns/1ps

module ddic_fetch_model (
	input wire logic i_clk,
	input wire logic i_thread,
	input wire logic [1:0] i_consume,
	output ddic_pkg::ddic_inst_t o_t0_slot0,
	output ddic_pkg::ddic_inst_t o_t0_slot1,
	output ddic_pkg::ddic_inst_t o_t1_slot0,
	output ddic_pkg::ddic_inst_t o_t1_slot1
);
	ddic_pkg::ddic_inst_t q[2][$];
	ddic_pkg::ddic_inst_t junk_q = '0;

	task automatic push(input logic t, input ddic_pkg::ddic_inst_t v);
		q[t].push_back(v);
	endtask : push

	// an empty slot shows changing garbage, never a stale copy of old data
	function automatic ddic_pkg::ddic_inst_t at(input int t, input int n);
		ddic_pkg::ddic_inst_t r;
		r = ~junk_q;
		r.valid = 1'b0;
		if (n < q[t].size())
			r = q[t][n];
		return r;
	endfunction : at

	task automatic show();
		o_t0_slot0 = at(0, 0);
		o_t0_slot1 = at(0, 1);
		o_t1_slot0 = at(1, 0);
		o_t1_slot1 = at(1, 1);
		junk_q = ~junk_q;
	endtask : show

	initial show();

	// a refused slot1 stays queued and moves up to slot0
	always @(negedge i_clk) begin
		for (int k = 0; k < 2; k++)
			if (i_consume[k] === 1'b1 && q[i_thread].size() > 0)
				void'(q[i_thread].pop_front());
		show();
	end
endmodule : ddic_fetch_model

/* ddic_top_tb.sv */
// ddic_top_tb: self-checking bench for decode pairing, issue hazards and events
// assumes the fetch model feeds slots; every issued instruction is accepted
`timescale 1ns/1ps

module ddic_top_tb;
	localparam logic [9:0] CX = 10'h200;
	localparam logic [9:0] JP = 10'h100;
	localparam logic [9:0] CJ = 10'h080;
	localparam logic [9:0] LF = 10'h040;
	localparam logic [9:0] FW = 10'h020;
	localparam logic [9:0] FC = 10'h010;
	localparam logic [9:0] FO = 10'h008;
	localparam logic [9:0] LL = 10'h004;
	localparam logic [9:0] EX = 10'h002;
	localparam logic [9:0] DV = 10'h001;
	typedef struct {
		logic [9:0] fa;
		logic [9:0] fb;
		logic [3:0] db;
		logic i1;
		logic [1:0] cons;
	} ddic_row_t;
	ddic_row_t rows[8];
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	ddic_pkg::ddic_inst_t s00, s01, s10, s11;
	logic [1:0] oldest = 2'h3;
	logic bp_lk = 1'b0, bp_up = 1'b0, bp_tk = 1'b0;
	logic [31:0] bp_pc = 32'h0, up_pc = 32'h0;
	logic [2:0] ev = 3'h0;
	logic [1:0] ret = 2'h0;
	logic thr, is0, is1, port, pred, micro, stl, ec, em, eb, last_port, stall_seen;
	logic [1:0] cns, dir, rc;
	int fail_count = 0, total_checks = 0, cyc = 0, n_iss = 0;
	int unsigned pc = 32'h1000;
	bit have_port = 0;

	initial forever #20 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	always @(negedge i_clk) begin
		if (stl === 1'b1) stall_seen = 1'b1;
		n_iss += (is0 === 1'b1) + (is1 === 1'b1);
	end

	ddic_fetch_model fetch_i (.i_clk(i_clk), .i_thread(thr), .i_consume(cns),
		.o_t0_slot0(s00), .o_t0_slot1(s01), .o_t1_slot0(s10), .o_t1_slot1(s11));

	ddic_top ddic_top_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_t0_slot0(s00),
		.i_t0_slot1(s01), .i_t1_slot0(s10), .i_t1_slot1(s11), .i_queue_oldest(oldest),
		.i_bp_lookup(bp_lk), .i_bp_pc(bp_pc), .i_bp_update(bp_up), .i_bp_upd_pc(up_pc),
		.i_bp_taken(bp_tk), .i_front_end_branch_clear(ev[0]), .i_icache_miss(ev[1]),
		.i_branch_mispredict_retired(ev[2]), .i_retire_count(ret), .o_thread(thr),
		.o_consume(cns), .o_issue0(is0), .o_issue1(is1), .o_issue0_port(port),
		.o_bp_predict_taken(pred), .o_microcoded_decode_event(micro),
		.o_direct_decode_event(dir), .o_decode_stall_event(stl),
		.o_front_end_branch_clear_event(ec), .o_instruction_cache_miss_event(em),
		.o_branch_type_mispredict_event(eb), .o_retire_count(rc));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic ddic_pkg::ddic_inst_t mk(input logic [31:0] a, input logic [3:0] l,
			input logic [9:0] f, input logic [3:0] d);
		return {1'b1, a, l, 3'h0, f, d};
	endfunction : mk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", n, e, s);
		end
	endtask : check

	task automatic tmo(input string n);
		fail_count++;
		$display("ERROR %s expected done seen timeout", n);
		stop_test();
	endtask : tmo

	task automatic wait_issue(input logic t, output int c);
		for (int k = 0; k < 60; k++) begin
			@(negedge i_clk);
			c = cyc;
			if (is0 === 1'b1 && thr === t) return;
		end
		tmo("issue");
	endtask : wait_issue

	// settles long-latency and window history before the next case
	task automatic drain();
		for (int k = 0; k < 80; k++) begin
			@(negedge i_clk);
			if (fetch_i.q[0].size() + fetch_i.q[1].size() == 0) begin
				repeat (8) @(negedge i_clk);
				return;
			end
		end
		tmo("drain");
	endtask : drain

	task automatic push_pair(input logic [9:0] fa, input logic [9:0] fb, input logic [3:0] db,
			input int off, input logic [3:0] l);
		fetch_i.push(1'b0, mk(pc + off, l, fa, 4'h1));
		fetch_i.push(1'b0, mk(pc + off + l, l, fb, db));
		fetch_i.show();
		pc += 32;
	endtask : push_pair

	task automatic gap(input logic [9:0] fa, input logic [9:0] fb, input int e, input bit exact);
		int c0, c1;
		push_pair(fa, fb, 4'h2, 0, 4'h4);
		wait_issue(1'b0, c0);
		check("split", 0, is1);
		if (!exact) begin
			@(negedge i_clk);
			check("issue after long", 0, is0);
		end
		wait_issue(1'b0, c1);
		total_checks++;
		if (exact ? (c1 - c0 != e) : (c1 - c0 < e)) begin
			fail_count++;
			$display("ERROR gap expected %0d seen %0d", e, c1 - c0);
		end
		drain();
	endtask : gap

	task automatic lat(input int off, output int l);
		int c, p;
		p = cyc;
		push_pair(10'h0, 10'h0, 4'h2, off, 4'h4);
		wait_issue(1'b0, c);
		l = c - p;
		drain();
	endtask : lat

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		int c, cm, ci, n, lb, lx;
		rows = '{'{10'h0, 10'h0, 4'h2, 1'b1, 2'h3},
			'{JP, 10'h0, 4'h2, 1'b0, 2'h1},
			'{10'h0, JP, 4'h2, 1'b1, 2'h3},
			'{LF, LF, 4'h2, 1'b0, 2'h1},
			'{FW, FC, 4'h2, 1'b0, 2'h1},
			'{DV, DV, 4'h1, 1'b0, 2'h1},
			'{DV, DV, 4'h2, 1'b1, 2'h3},
			'{10'h0, CX, 4'h2, 1'b0, 2'h1}};
		repeat (12) @(negedge i_clk);
		check("reset outputs", 0, {is0, is1, cns, micro, stl});
		i_resetn = 1'b1;
		@(negedge i_clk);
		check("outputs after reset", 0, {is0, is1, cns, micro, stl});
		for (int r = 0; r < 8; r++) begin
			push_pair(rows[r].fa, rows[r].fb, rows[r].db, 0, 4'h4);
			wait_issue(1'b0, c);
			check("issue1", rows[r].i1, is1);
			check("consume", rows[r].cons, cns);
			check("direct event", rows[r].cons, dir);
			if (is1 === 1'b1 && have_port) check("port", !last_port, port);
			if (is1 === 1'b1) begin
				have_port = 1;
				last_port = port;
			end
			drain();
		end
		// a flag carry reader or conditional jump may follow at once; others wait
		gap(FW, FC | CJ, 1, 1);
		gap(FW, FO, ddic_pkg::FLAG_OTHER_DELAY, 1);
		fetch_i.push(1'b1, mk(32'h8000, 4'h4, 10'h0, 4'h7));
		gap(LL, 10'h0, ddic_pkg::LONG_LAT_CYCLES, 0);
		lat(0, lb);
		lat(12, lx);
		check("boundary hold", lb + 1, lx);
		for (int k = 0; k < 2; k++) begin
			fetch_i.push(1'b0, mk(pc, k ? 4'hc : 4'h4, k ? 10'h0 : CX, 4'h1));
			fetch_i.show();
			pc += 32;
			for (cm = 0; cm < 40 && micro !== 1'b1; cm++) @(negedge i_clk);
			if (micro !== 1'b1) tmo("micro event");
			check("micro event", 1, micro);
			cm = cyc;
			wait_issue(1'b0, ci);
			check("ucode delay", ddic_pkg::UCODE_DELAY, ci - cm);
			drain();
		end
		stall_seen = 1'b0;
		n = n_iss;
		for (int k = 0; k < 6; k++) push_pair(10'h0, 10'h0, 4'h2, 0, 4'h8);
		drain();
		check("window stall", 1, stall_seen);
		check("issued count", n + 12, n_iss);
		oldest = 2'h0;
		n = n_iss;
		push_pair(EX, 10'h0, 4'h2, 0, 4'h4);
		repeat (6) @(negedge i_clk);
		check("expensive held", n, n_iss);
		oldest = 2'h3;
		wait_issue(1'b0, c);
		drain();
		for (int k = 0; k < 3; k++) begin
			ev = 3'b001 << k;
			@(negedge i_clk);
			ev = 3'h0;
			check("event echo", 3'b001 << k, {eb, em, ec});
		end
		ret = 2'h3;
		@(negedge i_clk);
		check("retire clamp", 2, rc);
		ret = 2'h0;
		bp_lk = 1'b1;
		bp_pc = 32'h0000_0105;
		@(negedge i_clk);
		check("predict before", 0, pred);
		bp_up = 1'b1;
		up_pc = 32'h0000_0005;
		bp_tk = 1'b1;
		@(negedge i_clk);
		bp_up = 1'b0;
		@(negedge i_clk);
		check("predict alias", 1, pred);
		stop_test();
	end
endmodule : ddic_top_tb
